// file: sim/gxp_i2c_master.sv
// serial bus master model for the link pins
module gxp_i2c_master (
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 625; // quarter bit at 400 kHz
    logic low_q = 1'b0;
    // pull-up: a released line reads high, never the last value
    assign sda = !(low_q || sda_oe);
    // clock stands still high between frames
    initial scl = 1'b1;
    // a released bit reads back what the target drives
    task automatic bits(input logic [7:0] b, output logic ack,
        output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            low_q = !b[i];
            #Q scl = 1'b1;
            #Q r[i] = sda;
            #Q scl = 1'b0;
            #Q;
        end
        low_q = 1'b0;
        #Q scl = 1'b1;
        #Q ack = !sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bits
    // start, address, command, data byte, stop
    // a read address with c of all ones returns one byte in r, then nack
    task automatic xfer(input logic [7:0] a, c, d, output logic [2:0] ack,
        output logic [7:0] r);
        logic [7:0] x;
        low_q = 1'b1;
        #Q scl = 1'b0;
        #Q;
        bits(a, ack[2], x);
        bits(c, ack[1], r);
        bits(d, ack[0], x);
        low_q = 1'b1;
        #Q scl = 1'b1;
        #Q low_q = 1'b0;
        #(4*Q);
    endtask : xfer
endmodule : gxp_i2c_master

// file: sim/tb.sv
// bench for the expander: bus master, pin models and checks
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = gxp_pkg::RESP_OKAY;
    localparam logic [1:0] ER = gxp_pkg::RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0, lclk = 1'b0, ext_rst_n = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, sel_lo = 1'b1, sel_hi = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, e0, e1, v, m, k, r;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, sda_oe, int_n_oe, scl, sda;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] d0, o0, d1, o1, p0, p1;
    logic [2:0] ack;
    logic [33:0] exp_q[$];
    int fail_count = 0, cmp_count = 0;
    integer seed = 32'h8c18;
    // ****
    // pins: a driven line shows its drive, others the outside level
    // ****
    assign p0 = (o0 & d0) | (~o0 & e0);
    assign p1 = (o1 & d1) | (~o1 & e1);
    always #12.5 aclk = ~aclk;
    initial begin
        #1.7;
        forever #3 lclk = ~lclk;
    end
    gxp_top i_gxp_top (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .lclk, .scl, .sda,
        .sda_drive(), .sda_oe, .ext_rst_n, .addr_select_lo(sel_lo),
        .addr_select_hi(sel_hi), .port0_line(p0), .port0_line_drv(d0),
        .port0_line_oe(o0), .port1_line(p1), .port1_line_drv(d1),
        .port1_line_oe(o1), .int_n(), .int_n_oe
    );
    gxp_i2c_master i_gxp_i2c_master (.sda_oe, .scl, .sda);
    task automatic check(input string n, input logic [33:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, x, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, x};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
        end while (bready);
    endtask : wr
    task automatic rd(input logic [7:0] a, x, input logic [1:0] r);
        exp_q.push_back({r, 24'h0, x});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
        end while (rready);
    endtask : rd
    // one queue serves both answers: a write and a read never overlap
    always @(posedge aclk) begin
        if (bvalid && bready) check("bresp", exp_q.pop_front(), {bresp, 32'h0});
        if (rvalid && rready) check("rdata", exp_q.pop_front(), {rresp, rdata});
    end
    initial begin
        e0 = $random(seed);
        e1 = $random(seed);
        tick(10);
        aresetn <= 1'b1;
        tick(3);
        check("oe", 34'h0, 34'({o1, o0}));
        check("drv", 34'hffff, 34'({d1, d0}));
        check("irq", 34'h0, 34'(int_n_oe));
        for (int i = 2; i < 8; i++) begin
            rd(8'(4 * i), (i inside {4, 5}) ? 8'h00 : 8'hff, OK);
        end
        rd(8'h00, e0, OK);
        rd(8'h04, e1, OK);
        wr(8'h00, ~e0, OK);
        rd(8'h00, e0, OK);
        m = $random(seed);
        v = $random(seed);
        k = $random(seed);
        wr(8'h14, m, OK);
        rd(8'h04, e1 ^ m, OK);
        wr(8'h08, v, OK);
        check("oe0", 34'h0, 34'(o0));
        wr(8'h18, k, OK);
        check("oe0", {26'h0, ~k}, 34'(o0));
        check("drv0", 34'(v), 34'(d0));
        tick(8);
        rd(8'h00, (v & ~k) | (e0 & k), OK);
        rd(8'h08, v, OK);
        tick(8);
        check("irq", 34'h0, 34'(int_n_oe));
        e1 <= ~e1;
        tick(8);
        check("irq", 34'h1, 34'(int_n_oe));
        e1 <= ~e1;
        tick(8);
        check("irq", 34'h0, 34'(int_n_oe));
        e1 <= ~e1;
        tick(8);
        rd(8'h04, e1 ^ m, OK);
        tick(4);
        check("irq", 34'h0, 34'(int_n_oe));
        wr(8'he0, 8'h5a, ER);
        rd(8'he0, 8'h00, ER);
        wr(8'h0c, k, OK);
        check("drv1", 34'(k), 34'(d1));
        i_gxp_i2c_master.xfer({gxp_pkg::TGT_BASE, sel_hi, sel_lo, 1'b0},
            8'h03, v, ack, r);
        check("ack", 34'h7, 34'(ack));
        tick(20);
        rd(8'h0c, v, OK);
        i_gxp_i2c_master.xfer({gxp_pkg::TGT_BASE, ~sel_hi, sel_lo, 1'b0},
            8'h03, ~v, ack, r);
        check("ack", 34'h0, 34'(ack));
        tick(20);
        rd(8'h0c, v, OK);
        ext_rst_n <= 1'b0;
        tick(6);
        check("oe", 34'h0, 34'({o1, o0}));
        ext_rst_n <= 1'b1;
        tick(10);
        rd(8'h0c, 8'hff, OK);
        rd(8'h18, 8'hff, OK);
        i_gxp_i2c_master.xfer({gxp_pkg::TGT_BASE, sel_hi, sel_lo, 1'b1},
            8'hff, 8'hff, ack, r);
        check("ack", 34'h4, 34'(ack));
        check("link rd", 34'(e0), 34'(r));
        conclude();
    end
    // three serial frames take about 220 us, bus traffic far less
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
endmodule : tb

// file: src/gxp_i2c_tgt.sv
// serial target engine on the link clock
module gxp_i2c_tgt (
    input wire logic lclk,
    input wire logic rst_src,
    input wire logic scl,
    input wire logic sda,
    input wire logic addr_select_lo,
    input wire logic addr_select_hi,
    input wire logic ack_tgl,
    input wire logic [7:0] ack_data,
    output logic sda_oe,
    output logic req_tgl,
    output logic req_we,
    output logic [2:0] req_ptr,
    output logic [7:0] req_wdata
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
    } gxp_st_t;
    gxp_st_t st_q, st_d, nxt_q, nxt_d;
    logic lrst_n, ack_s, scl_p_q, sda_p_q, drv_q, drv_d, oe_d, rq_d, rqwe_d;
    logic [3:0] lin;
    logic [2:0] cnt_q, cnt_d, ptr_q, ptr_d;
    logic [7:0] sh_q, sh_d;

    gxp_sync #(.W(1), .RV(1'h0)) u_rst (
        .clk(lclk), .rst_n(1'h1), .d(rst_src), .q(lrst_n));
    // oversampling filter; fast-mode phases span many link clocks
    gxp_sync #(.W(4), .RV(4'h3)) u_pin (
        .clk(lclk), .rst_n(lrst_n),
        .d({addr_select_hi, addr_select_lo, sda, scl}), .q(lin));
    gxp_sync #(.W(1), .RV(1'h0)) u_ack (
        .clk(lclk), .rst_n(lrst_n), .d(ack_tgl), .q(ack_s));

    wire scl_s = lin[0];
    wire sda_s = lin[1];
    wire [6:0] dev = {gxp_pkg::TGT_BASE, lin[3], lin[2]};
    wire rise = scl_s & ~scl_p_q;
    wire fall = ~scl_s & scl_p_q;
    wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire [7:0] byte_in = {sh_q[6:0], sda_s};
    wire last = (cnt_q == 3'h7);
    wire addr_hit = (byte_in[7:1] == dev);
    // a late register answer reads as released bus, never as stale data
    wire [7:0] load_val = (ack_s == req_tgl) ? ack_data : gxp_pkg::IDLE_BYTE;

    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        oe_d = sda_oe;
        drv_d = drv_q;
        ptr_d = ptr_q;
        rq_d = 1'h0;
        rqwe_d = 1'h0;
        if (start) begin
            st_d = ST_ADDR;
            cnt_d = 3'h0;
            oe_d = 1'h0;
            drv_d = 1'h0;
        end else if (stop) begin
            st_d = ST_IDLE;
            oe_d = 1'h0;
            drv_d = 1'h0;
        end else if (rise) begin
            cnt_d = cnt_q + 3'h1;
            case (st_q)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    sh_d = byte_in;
                    if (last) begin
                        st_d = ST_ACK;
                        if (st_q == ST_ADDR) begin
                            if (!addr_hit) st_d = ST_IDLE;
                            nxt_d = byte_in[0] ? ST_RDATA : ST_CMD;
                            rq_d = addr_hit & byte_in[0];
                        end else if (st_q == ST_CMD) begin
                            ptr_d = byte_in[2:0];
                            nxt_d = ST_WDATA;
                        end else begin
                            rq_d = 1'h1;
                            rqwe_d = 1'h1;
                        end
                    end
                end
                ST_RDATA: if (last) st_d = ST_MACK;
                ST_MACK: begin
                    if (sda_s) st_d = ST_IDLE;
                    else begin
                        rq_d = 1'h1;
                        drv_d = 1'h1;
                    end
                end
                default: ;
            endcase
        end else if (fall) begin
            case (st_q)
                ST_ACK: begin
                    oe_d = ~drv_q;
                    drv_d = ~drv_q;
                    if (drv_q) begin
                        st_d = nxt_q;
                        cnt_d = 3'h0;
                        if (nxt_q == ST_RDATA) begin
                            sh_d = load_val;
                            oe_d = ~load_val[7];
                        end
                    end
                end
                ST_RDATA: begin
                    sh_d = {sh_q[6:0], 1'h1};
                    oe_d = ~sh_q[6];
                end
                ST_MACK: begin
                    oe_d = 1'h0;
                    if (drv_q) begin
                        st_d = ST_RDATA;
                        cnt_d = 3'h0;
                        drv_d = 1'h0;
                        sh_d = load_val;
                        oe_d = ~load_val[7];
                    end
                end
                default: ;
            endcase
        end
        // registers pair up: pointer flips its port bit per byte
        if (rq_d) ptr_d = {ptr_q[2:1], ~ptr_q[0]};
    end

    always_ff @(posedge lclk) begin
        if (!lrst_n) begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            sda_oe <= 1'h0;
            drv_q <= 1'h0;
            ptr_q <= 3'h0;
            req_tgl <= 1'h0;
            req_we <= 1'h0;
            req_ptr <= 3'h0;
            req_wdata <= 8'h00;
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            sda_oe <= oe_d;
            drv_q <= drv_d;
            ptr_q <= ptr_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            req_tgl <= req_tgl ^ rq_d;
            if (rq_d) begin
                req_we <= rqwe_d;
                req_ptr <= ptr_q;
                req_wdata <= byte_in;
            end
        end
    end

    AST_ADDR_MISS: assert property (
        @(posedge lclk) disable iff (!lrst_n)
        !start && !stop && rise && st_q == ST_ADDR && last && !addr_hit
        |=> st_q == ST_IDLE && !sda_oe)
        else $error("foreign address was not ignored");
endmodule : gxp_i2c_tgt

// file: src/gxp_pkg.sv
// shared constants of the i2c gpio expander
// What this block does
// - sixteen lines as two byte ports with input, output, inversion, direction
// - after power-up every line is an input with its driver off
// - each direction bit sets its own line as input or output
// - input register holds sampled pin levels, output register the driven level
// - a set inversion bit inverts that line in input register reads
// - open-drain low interrupt while any pin differs from its captured value
// - power-on reset loads register defaults and idles the bus state machine
// - external low reset holds registers and state machine until released
// - two address-select pins form the low target address bits
// - serial target works at fast-mode rates up to 400 kHz
// - pin n of a port maps to bit n of that port's registers
// - command byte after address sets pointer; 0 to 7 select registers
// - direction one gives high-impedance input, zero drives the output bit
// - input registers are read-only, follow pins, ignore writes
// - output reads return the written value; no effect on input lines
package gxp_pkg;
    // ****************************************************************
    // register index: {group, port}; byte address is four times it
    // ****************************************************************
    localparam logic [1:0] GRP_IN = 2'h0;
    localparam logic [1:0] GRP_OUT = 2'h1;
    localparam logic [1:0] GRP_POL = 2'h2;
    localparam logic [1:0] GRP_DIR = 2'h3;
    localparam logic [2:0] IDX_IN0 = {GRP_IN, 1'h0};
    localparam logic [2:0] IDX_IN1 = {GRP_IN, 1'h1};
    localparam logic [2:0] IDX_OUT0 = {GRP_OUT, 1'h0};
    localparam logic [2:0] IDX_OUT1 = {GRP_OUT, 1'h1};
    localparam logic [2:0] IDX_DIR0 = {GRP_DIR, 1'h0};
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;
    localparam int ADDR_W = 8;
    // ****************************************************************
    // reset values and answers
    // ****************************************************************
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // upper target address bits, value arbitrary
    localparam logic [4:0] TGT_BASE = 5'h12;
    localparam int FAST_MODE_HZ = 400000;
endpackage : gxp_pkg

// file: src/gxp_sync.sv
// three-stage synchroniser with agreement filter
module gxp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RV = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // a bit moves only once stages two and three agree
    assign q_d = (s2_q & s3_q) | (q & (s2_q | s3_q));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= RV;
            s2_q <= RV;
            s3_q <= RV;
            q <= RV;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q <= q_d;
        end
    end
endmodule : gxp_sync

// file: src/gxp_top.sv
// gpio expander: register file, axi4-lite slave, pins, interrupt
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module gxp_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gxp_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [gxp_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic lclk,
    input wire logic scl,
    input wire logic sda,
    output logic sda_drive,
    output logic sda_oe,
    input wire logic ext_rst_n,
    input wire logic addr_select_lo,
    input wire logic addr_select_hi,
    input wire logic [7:0] port0_line,
    output logic [7:0] port0_line_drv,
    output logic [7:0] port0_line_oe,
    input wire logic [7:0] port1_line,
    output logic [7:0] port1_line_drv,
    output logic [7:0] port1_line_oe,
    output logic int_n,
    output logic int_n_oe
);
    // ****************************************************************
    // reset, pin sampling and the link crossing
    // ****************************************************************
    logic ext_ok, srst_q, req_s, i2c_we, i2c_tgl;
    logic [2:0] i2c_ptr;
    logic [7:0] i2c_wdata;
    logic [1:0][7:0] pins;

    gxp_sync #(.W(1), .RV(1'h1)) u_ext (
        .clk(aclk), .rst_n(aresetn), .d(ext_rst_n), .q(ext_ok));
    // pin stages run through reset so they hold true levels at release
    gxp_sync #(.W(16), .RV(16'h0000)) u_pins (
        .clk(aclk), .rst_n(1'h1), .d({port1_line, port0_line}), .q(pins));

    wire srst_n = aresetn & ext_ok;

    // held in reset with the registers so no stale link request survives
    gxp_sync #(.W(1), .RV(1'h0)) u_req (
        .clk(aclk), .rst_n(srst_n), .d(i2c_tgl), .q(req_s));

    always_ff @(posedge aclk) begin
        srst_q <= srst_n;
    end

    // ****************************************************************
    // register state and the bus slave holding registers
    // ****************************************************************
    logic [1:0][7:0] out_q, pol_q, en_q, cap_q;
    logic init_q, irq_q, ack_tgl_q, req_seen_q;
    logic [7:0] ack_data_q;
    logic aw_full_q, w_full_q, wstrb_q, awready_q, wready_q;
    logic bvalid_q, rvalid_q, arready_q;
    logic [1:0] bresp_q, rresp_q;
    logic [gxp_pkg::ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic [31:0] rdata_q;

    gxp_i2c_tgt u_tgt (
        .lclk(lclk),
        .rst_src(srst_q),
        .scl(scl),
        .sda(sda),
        .addr_select_lo(addr_select_lo),
        .addr_select_hi(addr_select_hi),
        .ack_tgl(ack_tgl_q),
        .ack_data(ack_data_q),
        .sda_oe(sda_oe),
        .req_tgl(i2c_tgl),
        .req_we(i2c_we),
        .req_ptr(i2c_ptr),
        .req_wdata(i2c_wdata)
    );

    wire [1:0][7:0] in_view = pins ^ pol_q;

    // all state comes in as arguments, so a continuous caller tracks it
    function automatic logic [7:0] rd_sel(
        input logic [2:0] idx,
        input logic [1:0][7:0] iv,
        input logic [1:0][7:0] ov,
        input logic [1:0][7:0] pv,
        input logic [1:0][7:0] ev
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx[2:1])
            gxp_pkg::GRP_IN: v = iv[idx[0]];
            gxp_pkg::GRP_OUT: v = ov[idx[0]];
            gxp_pkg::GRP_POL: v = pv[idx[0]];
            default: v = ~ev[idx[0]];
        endcase
        return v;
    endfunction : rd_sel

    // ****************************************************************
    // decode and selection
    // ****************************************************************
    wire aw_take = awvalid & awready_q;
    wire w_take = wvalid & wready_q;
    wire ar_take = arvalid & arready_q;
    wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
    wire [2:0] aw_idx = awaddr_q[gxp_pkg::IDX_MSB:gxp_pkg::IDX_LSB];
    wire aw_map = (awaddr_q[gxp_pkg::ADDR_W-1:gxp_pkg::IDX_MSB+1] == '0);
    wire [2:0] ar_idx = araddr[gxp_pkg::IDX_MSB:gxp_pkg::IDX_LSB];
    wire ar_map = (araddr[gxp_pkg::ADDR_W-1:gxp_pkg::IDX_MSB+1] == '0);
    // bus write wins the cycle; a link write waits one turn
    wire i2c_go = (req_s ^ req_seen_q) & ~(wr_go & i2c_we);
    wire ax_we = wr_go & aw_map & wstrb_q;
    wire we = ax_we | (i2c_go & i2c_we);
    wire [2:0] widx = ax_we ? aw_idx : i2c_ptr;
    wire [7:0] wval = ax_we ? wdata_q : i2c_wdata;
    wire wr_out = we & (widx[2:1] == gxp_pkg::GRP_OUT);
    wire wr_pol = we & (widx[2:1] == gxp_pkg::GRP_POL);
    wire wr_dir = we & (widx[2:1] == gxp_pkg::GRP_DIR);
    wire ax_in_rd = ar_take & ar_map & (ar_idx[2:1] == gxp_pkg::GRP_IN);
    wire ic_in_rd = i2c_go & ~i2c_we & (i2c_ptr[2:1] == gxp_pkg::GRP_IN);
    wire aw_full_d = (aw_full_q & ~wr_go) | aw_take;
    wire w_full_d = (w_full_q & ~wr_go) | w_take;
    wire rvalid_d = ar_take | (rvalid_q & ~rready);
    wire [7:0] rd_ax = ar_map ?
        rd_sel(ar_idx, in_view, out_q, pol_q, en_q) : 8'h00;

    // ****************************************************************
    // port registers, capture and interrupt
    // ****************************************************************
    always_ff @(posedge aclk) begin
        for (int p = 0; p < 2; p++) begin
            if (!srst_n) begin
                out_q[p] <= gxp_pkg::OUT_RST;
                pol_q[p] <= gxp_pkg::POL_RST;
                en_q[p] <= ~gxp_pkg::DIR_RST;
                cap_q[p] <= 8'h00;
            end else begin
                // input group has no write branch
                if (wr_out && widx[0] == p[0]) out_q[p] <= wval;
                if (wr_pol && widx[0] == p[0]) pol_q[p] <= wval;
                // one in direction means input, so the enable is inverted
                if (wr_dir && widx[0] == p[0]) en_q[p] <= ~wval;
                if (init_q || (ax_in_rd && ar_idx[0] == p[0]) ||
                    (ic_in_rd && i2c_ptr[0] == p[0])) begin
                    cap_q[p] <= pins[p];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            init_q <= 1'h1;
            irq_q <= 1'h0;
            ack_tgl_q <= 1'h0;
            req_seen_q <= 1'h0;
            ack_data_q <= 8'h00;
        end else begin
            init_q <= 1'h0;
            irq_q <= ~init_q && (pins != cap_q);
            if (i2c_go) begin
                ack_tgl_q <= ~ack_tgl_q;
                req_seen_q <= req_s;
                ack_data_q <= rd_sel(i2c_ptr, in_view, out_q, pol_q, en_q);
            end
        end
    end

    // ****************************************************************
    // bus slave handshakes
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            aw_full_q <= 1'h0;
            w_full_q <= 1'h0;
            awready_q <= 1'h0;
            wready_q <= 1'h0;
            bvalid_q <= 1'h0;
            bresp_q <= gxp_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            bvalid_q <= wr_go | (bvalid_q & ~bready);
            if (aw_take) awaddr_q <= awaddr;
            if (w_take) wdata_q <= wdata[7:0];
            if (w_take) wstrb_q <= wstrb[0];
            if (wr_go) begin
                bresp_q <= aw_map ? gxp_pkg::RESP_OKAY : gxp_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            arready_q <= 1'h0;
            rvalid_q <= 1'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= gxp_pkg::RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= {24'h00_0000, rd_ax};
                rresp_q <= ar_map ? gxp_pkg::RESP_OKAY : gxp_pkg::RESP_SLVERR;
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign port0_line_drv = out_q[0];
    assign port1_line_drv = out_q[1];
    assign port0_line_oe = en_q[0];
    assign port1_line_oe = en_q[1];
    // open-drain lines only ever pull low
    assign int_n = 1'h0;
    assign int_n_oe = irq_q;
    assign sda_drive = 1'h0;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_EXT_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!ext_ok) [*2] |-> en_q == '0 && !bvalid_q && !rvalid_q
        && out_q == {2{gxp_pkg::OUT_RST}})
        else $error("external reset did not hold defaults");

    AST_RESET_DEF: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !ext_ok ##1 ext_ok |-> pol_q == {2{gxp_pkg::POL_RST}}
        && port1_line_oe == 8'h00 && !int_n_oe)
        else $error("register defaults wrong after reset");

    AST_DIR_READ: assert property (
        @(posedge aclk) disable iff (!srst_n)
        ar_take && ar_map && ar_idx == gxp_pkg::IDX_DIR0
        |=> rvalid_q && rdata_q[7:0] == ~port0_line_oe)
        else $error("direction read does not match line enables");

    AST_POL_READ: assert property (
        @(posedge aclk) disable iff (!srst_n)
        ar_take && ar_map && ar_idx == gxp_pkg::IDX_IN1
        |=> rdata_q[7:0] == $past(pins[1] ^ pol_q[1]))
        else $error("input read ignores inversion");

    AST_IN_RO: assert property (
        @(posedge aclk) disable iff (!srst_n)
        wr_go && aw_map && aw_idx == gxp_pkg::IDX_IN0
        |=> $stable(out_q) && $stable(pol_q) && $stable(en_q)
        && bresp_q == gxp_pkg::RESP_OKAY)
        else $error("write to input register changed state");

    AST_OUT_WR: assert property (
        @(posedge aclk) disable iff (!srst_n)
        ax_we && aw_idx == gxp_pkg::IDX_OUT1
        |=> port1_line_drv == $past(wdata_q) ##1 bvalid_q || $past(bready))
        else $error("output register write lost");

    AST_INT_SET: assert property (
        @(posedge aclk) disable iff (!srst_n)
        !init_q && pins != cap_q |=> int_n_oe)
        else $error("pin change did not raise interrupt");

    AST_INT_CLR: assert property (
        @(posedge aclk) disable iff (!srst_n)
        ax_in_rd && ar_idx[0] == 1'h0 && !we
        |=> cap_q[0] == $past(pins[0]))
        else $error("input read did not recapture port 0");

    AST_LINK_ONE: assert property (
        @(posedge aclk) disable iff (!srst_n)
        i2c_go |=> !(req_s ^ req_seen_q) && ack_tgl_q != $past(ack_tgl_q))
        else $error("link request served twice or not answered");

    AST_RD_UNMAP: assert property (
        @(posedge aclk) disable iff (!srst_n)
        ar_take && !ar_map |=> rvalid_q && rresp_q == gxp_pkg::RESP_SLVERR
        && rdata_q == 32'h0000_0000)
        else $error("unmapped read was not refused");
endmodule : gxp_top
